// *** hw/las_map.vh ***
// Register offsets, field positions and codes of the line attribute setup block.
`ifndef LAS_MAP_VH
`define LAS_MAP_VH
// ****************************************
// Register byte addresses
// ****************************************
`define LAS_ADDR_W 16
`define LAS_OFF_CMD 16'hB100
`define LAS_OFF_GREEN_STEP 16'hB144
`define LAS_OFF_ALPHA_RED_STEP 16'hB148
`define LAS_OFF_GREEN_BLUE_INIT 16'hB14C
`define LAS_OFF_ALPHA_RED_INIT 16'hB150
`define LAS_OFF_DEPTH_STEP 16'hB158
`define LAS_OFF_DEPTH_INIT 16'hB15C
`define LAS_OFF_X_ENDPOINTS 16'hB16C
`define LAS_OFF_HORIZ_STEP 16'hB170
`define LAS_OFF_HORIZ_INIT 16'hB174
`define LAS_OFF_FIRST_SCANLINE 16'hB178
`define LAS_OFF_SCANLINE_COUNT 16'hB17C
`define LAS_OFF_STATUS 16'hB180
// ****************************************
// Field positions
// ****************************************
`define LAS_AUTO_LAUNCH_BIT 0
`define LAS_CMD_HI 30
`define LAS_CMD_LO 27
`define LAS_CMD_LINE 4'h8
`define LAS_CMD_NOP 4'hF
`define LAS_CMD_RESET 32'h78000000
`define LAS_LINE_HI 10
`define LAS_DIR_BIT 31
`define LAS_HALF_HI 31
`define LAS_HALF_LO 16
`define LAS_COL_INT_HI 14
`define LAS_COL_INT_LO 7
`define LAS_X_INT_HI 30
`define LAS_X_INT_LO 20
`define LAS_END_MSB 10
`endif

// *** hw/las_line_setup.v ***
// Line attribute register bank with APB slave and scan-line stepping engine.
// Behaviour
// - Green, red and alpha steps are signed 16-bit values, eight integer bits.
// - Green step sits in bits 31 to 16 and accumulates green.
// - Depth step is a signed 32-bit value accumulated into depth.
// - Endpoint low half: top line last pixel x, bits 15-11 zero.
// - Endpoint high half: bottom line first pixel x, bits 31-27 zero.
// - Horizontal step is a signed 32-bit value accumulated into x.
// - First scan line is bits 10-0 of its register; upper bits reserved.
// - Lines are stepped upward from the bottom, y decreasing each line.
// - Auto launch: count write starts; otherwise command write starts.
// - Number of scan lines comes from count bits 10-0.
// - Count bit 31 gives direction: 0 right-to-left, 1 left-to-right.
//
// Added by the designer: the APB slave port.
`timescale 1ns/10ps
`include "las_map.vh"
module las_line_setup (
	input wire clk_sys, // System clock, 125 MHz.
	input wire rstn, // Asynchronous reset, active low.
	input wire psel, // APB select.
	input wire penable, // APB enable.
	input wire pwrite, // APB direction, high for write.
	input wire [15:0] paddr, // APB byte address.
	input wire [31:0] pwdata, // APB write data.
	output reg [31:0] prdata, // APB read data.
	output reg pready, // APB ready.
	output reg pslverr, // APB error for unmapped address.
	output reg line_busy, // Engine is stepping a line.
	output reg pix_valid, // One pulse per scan line stepped.
	output reg [10:0] pix_y, // Current scan line.
	output reg [10:0] pix_x, // Integer part of current x.
	output reg [31:0] pix_color, // Alpha, red, green, blue integer parts.
	output reg [31:0] pix_z, // Current depth.
	output reg pix_left_to_right, // Span direction of the line.
	output reg [10:0] top_line_last_x, // Last pixel x on topmost line.
	output reg [10:0] bottom_line_first_x // First pixel x on bottommost line.
);

// ****************************************
// Register storage
// ****************************************
	// Parameter words as software last wrote them.
	reg [31:0] cmd_ff;
	reg [15:0] green_step_ff;
	reg [31:0] alpha_red_step_ff;
	reg [31:0] green_blue_init_ff;
	reg [31:0] alpha_red_init_ff;
	reg [31:0] depth_step_ff;
	reg [31:0] depth_init_ff;
	reg [31:0] x_endpoints_ff;
	reg [31:0] horiz_step_ff;
	reg [31:0] horiz_init_ff;
	reg [10:0] first_scanline_ff;
	reg [10:0] scanline_count_ff;

	// Engine state and running accumulators.
	reg dir_ff;
	reg [10:0] lines_left_ff;
	reg [10:0] y_ff;
	reg [31:0] x_acc_ff;
	reg [31:0] z_acc_ff;
	reg [63:0] col_acc_ff;
	reg [2:0] state_ff;
	reg [2:0] nxt_state;

	// Read path and launch decode.
	reg [31:0] rd_mux;
	reg rd_hit;
	wire setup_ph;
	wire wr_access;
	wire [63:0] col_step;
	wire [63:0] nxt_col;
	wire cmd_launch;
	wire cnt_launch;
	wire launch;

	// One-hot engine states.
	localparam [2:0] ST_IDLE = 3'b001;
	localparam [2:0] ST_LOAD = 3'b010;
	localparam [2:0] ST_STEP = 3'b100;

	// Setup is the only cycle in which the slave decodes the address for reads.
	assign setup_ph = psel & ~penable;
	// A write lands only at the access edge, and never for an unmapped address.
	assign wr_access = psel & penable & pready & pwrite & ~pslverr;

// ****************************************
// APB slave
// ****************************************
	// Read data is captured in the setup cycle so every access takes exactly one
	// access cycle; the value seen is the register contents at that setup edge.
	// Unstored bits and the reserved scan-line and count bits read as zero; other words, endpoints included, read back whole.
	always @* begin
		rd_hit = 1'b1;
		rd_mux = 32'h00000000;
		case (paddr)
			`LAS_OFF_CMD: rd_mux = cmd_ff;
			`LAS_OFF_GREEN_STEP: rd_mux = {green_step_ff, 16'h0000};
			`LAS_OFF_ALPHA_RED_STEP: rd_mux = alpha_red_step_ff;
			`LAS_OFF_GREEN_BLUE_INIT: rd_mux = green_blue_init_ff;
			`LAS_OFF_ALPHA_RED_INIT: rd_mux = alpha_red_init_ff;
			`LAS_OFF_DEPTH_STEP: rd_mux = depth_step_ff;
			`LAS_OFF_DEPTH_INIT: rd_mux = depth_init_ff;
			`LAS_OFF_X_ENDPOINTS: rd_mux = x_endpoints_ff;
			`LAS_OFF_HORIZ_STEP: rd_mux = horiz_step_ff;
			`LAS_OFF_HORIZ_INIT: rd_mux = horiz_init_ff;
			`LAS_OFF_FIRST_SCANLINE: rd_mux = {21'h000000, first_scanline_ff};
			`LAS_OFF_SCANLINE_COUNT: rd_mux = {dir_ff, 20'h00000, scanline_count_ff};
			`LAS_OFF_STATUS: rd_mux = {line_busy, 4'h0, lines_left_ff, 5'h00, y_ff};
			default: rd_hit = 1'b0;
		endcase
	end

	// Ready rises for one cycle after every setup cycle; there are no wait states.
	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else if (setup_ph) begin
			// Write cycles and unmapped addresses return zero read data.
			pready <= 1'b1;
			pslverr <= ~rd_hit;
			prdata <= (pwrite || !rd_hit) ? 32'h00000000 : rd_mux;
		end else begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	// Parameter registers carry no reset so power-on contents stay undefined.
	always @(posedge clk_sys) begin
		if (wr_access) begin
			case (paddr)
				`LAS_OFF_GREEN_STEP: green_step_ff <= pwdata[`LAS_HALF_HI:`LAS_HALF_LO];
				`LAS_OFF_ALPHA_RED_STEP: alpha_red_step_ff <= pwdata;
				`LAS_OFF_GREEN_BLUE_INIT: green_blue_init_ff <= pwdata;
				`LAS_OFF_ALPHA_RED_INIT: alpha_red_init_ff <= pwdata;
				`LAS_OFF_DEPTH_STEP: depth_step_ff <= pwdata;
				`LAS_OFF_DEPTH_INIT: depth_init_ff <= pwdata;
				`LAS_OFF_X_ENDPOINTS: x_endpoints_ff <= pwdata;
				`LAS_OFF_HORIZ_STEP: horiz_step_ff <= pwdata;
				`LAS_OFF_HORIZ_INIT: horiz_init_ff <= pwdata;
				`LAS_OFF_FIRST_SCANLINE: first_scanline_ff <= pwdata[`LAS_LINE_HI:0];
				`LAS_OFF_SCANLINE_COUNT: scanline_count_ff <= pwdata[`LAS_LINE_HI:0];
				// The command word lives in the reset block below; status writes are dropped.
				default: ;
			endcase
		end
	end

	// Command and direction are control state and so do get a reset value.
	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			cmd_ff <= `LAS_CMD_RESET;
			dir_ff <= 1'b0;
		end else if (wr_access) begin
			// A command write is stored whether or not it launches.
			if (paddr == `LAS_OFF_CMD)
				cmd_ff <= pwdata;
			// Direction is latched on every count write, launched or not.
			if (paddr == `LAS_OFF_SCANLINE_COUNT)
				dir_ff <= pwdata[`LAS_DIR_BIT];
		end
	end

// ****************************************
// Launch decode
// ****************************************
	// A NOP command write clears auto launch without starting anything.
	// Any code other than the line command is only stored and starts nothing.
	assign cmd_launch = wr_access && (paddr == `LAS_OFF_CMD) && !pwdata[`LAS_AUTO_LAUNCH_BIT]
		&& (pwdata[`LAS_CMD_HI:`LAS_CMD_LO] == `LAS_CMD_LINE);
	assign cnt_launch = wr_access && (paddr == `LAS_OFF_SCANLINE_COUNT)
		&& cmd_ff[`LAS_AUTO_LAUNCH_BIT]
		&& (cmd_ff[`LAS_CMD_HI:`LAS_CMD_LO] == `LAS_CMD_LINE);
	assign launch = cmd_launch | cnt_launch;

// ****************************************
// Colour accumulators
// ****************************************
	// Lanes: 0 blue, 1 green, 2 red, 3 alpha. Blue has no stored step and holds.
	// Lanes wrap on overflow with no clamp; software keeps the end values in range.
	assign col_step = {alpha_red_step_ff, green_step_ff, 16'h0000};

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_col
			assign nxt_col[gi*16 +: 16] = col_acc_ff[gi*16 +: 16] + col_step[gi*16 +: 16];
		end
	endgenerate

// ****************************************
// Line engine
// ****************************************
	always @* begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE: begin
				if (launch)
					nxt_state = ST_LOAD;
			end
			ST_LOAD: begin
				// A zero count goes straight back to idle without a single step.
				if (lines_left_ff == 11'h000)
					nxt_state = ST_IDLE;
				else
					nxt_state = ST_STEP;
			end
			ST_STEP: begin
				if (lines_left_ff == 11'h001)
					nxt_state = ST_IDLE;
			end
			default: nxt_state = ST_IDLE;
		endcase
	end

	// Launches that arrive while busy are ignored; the parameters are still stored.
	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			state_ff <= ST_IDLE;
			lines_left_ff <= 11'h000;
			y_ff <= 11'h000;
			x_acc_ff <= 32'h00000000;
			z_acc_ff <= 32'h00000000;
			col_acc_ff <= 64'h0000000000000000;
			line_busy <= 1'b0;
			pix_valid <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			// The strobe defaults low so each STEP cycle gives exactly one pulse.
			pix_valid <= 1'b0;
			case (state_ff)
				ST_IDLE: begin
					// A count-write launch takes the count from the bus, as its copy lags an edge.
					if (launch) begin
						line_busy <= 1'b1;
						lines_left_ff <= cnt_launch ? pwdata[`LAS_LINE_HI:0] : scanline_count_ff;
					end
				end
				ST_LOAD: begin
					// The bottom line has the largest y, so y counts down as lines go up.
					y_ff <= first_scanline_ff;
					x_acc_ff <= horiz_init_ff;
					z_acc_ff <= depth_init_ff;
					col_acc_ff <= {alpha_red_init_ff, green_blue_init_ff};
					if (lines_left_ff == 11'h000)
						line_busy <= 1'b0;
				end
				ST_STEP: begin
					// Step words are read live, so rewriting them mid-line bends the line.
					pix_valid <= 1'b1;
					lines_left_ff <= lines_left_ff - 11'h001;
					y_ff <= y_ff - 11'h001;
					x_acc_ff <= x_acc_ff + horiz_step_ff;
					z_acc_ff <= z_acc_ff + depth_step_ff;
					col_acc_ff <= nxt_col;
					if (lines_left_ff == 11'h001)
						line_busy <= 1'b0;
				end
				default: line_busy <= 1'b0;
			endcase
		end
	end

// ****************************************
// Pixel outputs
// ****************************************
	// Values shown with each pulse are those of the line before the step is added.
	// Only the integer part of each colour lane and of x leaves the block.
	// Endpoints and direction are copied with each pulse for one consistent set.
	// All pixel outputs hold their last values between pulses.
	always @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			pix_y <= 11'h000;
			pix_x <= 11'h000;
			pix_color <= 32'h00000000;
			pix_z <= 32'h00000000;
			pix_left_to_right <= 1'b0;
			top_line_last_x <= 11'h000;
			bottom_line_first_x <= 11'h000;
		end else if (state_ff == ST_STEP) begin
			pix_y <= y_ff;
			pix_x <= x_acc_ff[`LAS_X_INT_HI:`LAS_X_INT_LO];
			pix_color <= {col_acc_ff[48+`LAS_COL_INT_HI:48+`LAS_COL_INT_LO],
				col_acc_ff[32+`LAS_COL_INT_HI:32+`LAS_COL_INT_LO],
				col_acc_ff[16+`LAS_COL_INT_HI:16+`LAS_COL_INT_LO],
				col_acc_ff[`LAS_COL_INT_HI:`LAS_COL_INT_LO]};
			pix_z <= z_acc_ff;
			pix_left_to_right <= dir_ff;
			top_line_last_x <= x_endpoints_ff[`LAS_END_MSB:0];
			bottom_line_first_x <= x_endpoints_ff[`LAS_HALF_LO+`LAS_END_MSB:`LAS_HALF_LO];
		end
	end
endmodule // las_line_setup

// *** testbench/las_line_setup_properties.sv ***
// Port checker for the line attribute setup block.
`timescale 1ns/10ps
`include "las_map.vh"
module las_line_setup_chk (
	input wire clk_sys, // Clock.
	input wire rstn, // Reset, active low.
	input wire psel, // Select.
	input wire penable, // Enable.
	input wire pwrite, // Direction.
	input wire [15:0] paddr, // Address.
	input wire [31:0] pwdata, // Write data.
	input wire [31:0] prdata, // Read data.
	input wire pready, // Ready.
	input wire pslverr, // Error.
	input wire line_busy, // Busy.
	input wire pix_valid, // Line strobe.
	input wire [10:0] pix_y, // Scan line.
	input wire [31:0] pix_z // Depth.
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	wire acc_done = psel && penable && pready;
	// The step is only known as a difference, so depth is checked for constant spacing.
	property p_ready_next; psel && !penable |=> pready; endproperty
	a_ready_next: assert property (p_ready_next) else $error("ready missing");
	property p_ready_single; pready |=> !pready; endproperty
	a_ready_single: assert property (p_ready_single) else $error("ready too long");
	property p_unmapped; pready && paddr[15:8] != 8'hB1 |-> pslverr; endproperty
	a_unmapped: assert property (p_unmapped) else $error("no error on unmapped");
	property p_ystart_rsvd;
		acc_done && !pwrite && paddr == `LAS_OFF_FIRST_SCANLINE |-> prdata[31:11] == 21'h0;
	endproperty
	a_ystart_rsvd: assert property (p_ystart_rsvd) else $error("reserved bits set");
	property p_launch; acc_done && pwrite && paddr == `LAS_OFF_CMD && pwdata[30:27] == 4'h8
		&& !pwdata[0] && !line_busy |=> line_busy; endproperty
	a_launch: assert property (p_launch) else $error("command did not start");
	property p_y_down; pix_valid ##1 pix_valid |-> pix_y == $past(pix_y) - 11'h1; endproperty
	a_y_down: assert property (p_y_down) else $error("scan line not stepped up");
	property p_z_step;
		pix_valid [*3] |-> pix_z - $past(pix_z) == $past(pix_z) - $past(pix_z, 2);
	endproperty
	a_z_step: assert property (p_z_step) else $error("depth step uneven");
	property p_valid_busy; pix_valid |-> $past(line_busy); endproperty
	a_valid_busy: assert property (p_valid_busy) else $error("strobe while idle");
endmodule // las_line_setup_chk
bind las_line_setup las_line_setup_chk i_las_line_setup_chk (.clk_sys(clk_sys), .rstn(rstn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .line_busy(line_busy),
	.pix_valid(pix_valid), .pix_y(pix_y), .pix_z(pix_z));

// *** testbench/las_line_setup_tb_top.sv ***
// Self-checking bench for the line attribute setup block.
`timescale 1ns/10ps
`include "las_map.vh"
module las_line_setup_tb_top;
	logic clk_sys = 1'b0;
	logic rstn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [15:0] paddr = 16'h0000;
	logic [31:0] pwdata = 32'h0;
	wire [31:0] prdata, pix_color, pix_z;
	wire pready, pslverr, line_busy, pix_valid, pix_left_to_right;
	wire [10:0] pix_y, pix_x, top_line_last_x, bottom_line_first_x;
	logic [31:0] rd;
	logic err;
	int n_errors = 0;
	int cmp_count = 0;
	int i;
	logic [15:0] ad [10] = '{16'hB144, 16'hB148, 16'hB14C, 16'hB150, 16'hB158, 16'hB15C,
		16'hB16C, 16'hB170, 16'hB174, 16'hB178};
	logic [31:0] wd [10] = '{32'h0080_1234, 32'hFF80_0100, 32'h0A00_0380,
		32'h7F80_0500, 32'hFFFF_8000, 32'h0010_0000, 32'h0123_0456,
		32'h0018_0000, 32'h0640_0000, 32'hABCD_E07F};
	las_line_setup i_las_line_setup (.clk_sys(clk_sys), .rstn(rstn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .line_busy(line_busy), .pix_valid(pix_valid),
		.pix_y(pix_y), .pix_x(pix_x), .pix_color(pix_color), .pix_z(pix_z),
		.pix_left_to_right(pix_left_to_right), .top_line_last_x(top_line_last_x),
		.bottom_line_first_x(bottom_line_first_x));
	always #4 clk_sys = ~clk_sys;
	task chk(input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			n_errors++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	// The request stands until pready is seen high at a rising edge; data is taken there.
	task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task run(input int n, input logic dir);
		int k;
		int w;
		logic [15:0] g, r, a;
		logic [31:0] x;
		for (k = 0; k < n; k++) begin
			w = 0;
			do @(negedge clk_sys); while (pix_valid !== 1'b1 && ++w < 20);
			g = wd[2][31:16] + k * wd[0][31:16];
			a = wd[3][31:16] + k * wd[1][31:16];
			r = wd[3][15:0] + k * wd[1][15:0];
			x = wd[8] + k * wd[7];
			chk(pix_color, {a[14:7], r[14:7], g[14:7], wd[2][14:7]});
			chk(pix_z, wd[5] + k * wd[4]);
			chk({9'h0, pix_left_to_right, pix_y, pix_x},
				{9'h0, dir, 11'h07F - k[10:0], x[30:20]});
			chk({10'h0, top_line_last_x, bottom_line_first_x},
				{10'h0, wd[6][10:0], wd[6][26:16]});
		end
		@(negedge clk_sys);
		chk({30'h0, line_busy, pix_valid}, 32'h0);
	endtask
	task conclude;
		$display("errors=%0d compares=%0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge clk_sys);
		n_errors++;
		conclude;
	end
	initial begin
		repeat (20) @(posedge clk_sys);
		rstn <= 1'b1;
		for (i = 0; i < 10; i++) apb(1'b1, ad[i], wd[i]);
		for (i = 0; i < 10; i++) begin
			apb(1'b0, ad[i], 32'h0);
			chk(rd, ad[i] == 16'hB144 ? {wd[i][31:16], 16'h0} : ad[i] == 16'hB178 ?
				{21'h0, wd[i][10:0]} : wd[i]);
		end
		apb(1'b0, 16'h0000, 32'h0);
		chk({rd[31:1], err}, 32'h1);
		apb(1'b1, `LAS_OFF_SCANLINE_COUNT, 32'h8000_0003);
		apb(1'b0, `LAS_OFF_SCANLINE_COUNT, 32'h0);
		chk(rd, 32'h8000_0003);
		apb(1'b1, `LAS_OFF_CMD, 32'h4000_0000);
		run(3, 1'b1);
		apb(1'b1, `LAS_OFF_CMD, 32'h4000_0001);
		@(negedge clk_sys);
		chk({31'h0, line_busy}, 32'h0);
		apb(1'b0, `LAS_OFF_CMD, 32'h0);
		chk(rd, 32'h4000_0001);
		apb(1'b1, `LAS_OFF_SCANLINE_COUNT, 32'h7FFF_F802);
		run(2, 1'b0);
		apb(1'b0, `LAS_OFF_STATUS, 32'h0);
		chk(rd, 32'h0000_007D);
		apb(1'b1, `LAS_OFF_CMD, 32'h7800_0000);
		apb(1'b1, `LAS_OFF_SCANLINE_COUNT, 32'h0000_0002);
		@(negedge clk_sys);
		chk({31'h0, line_busy}, 32'h0);
		apb(1'b0, `LAS_OFF_SCANLINE_COUNT, 32'h0);
		chk(rd, 32'h0000_0002);
		conclude;
	end
endmodule // las_line_setup_tb_top
